// >>> hw/iop_port.sv
// Notes on behaviour
// - port widths 1,4,8,16,32; one direction
// - open drain: zero pulls low, one floats
// - drive pins or sample, optionally conditioned
// - each core access completes in one cycle
// - data passes through serdes and transfer register
// - every port owns a 16-bit counter
// - counter readable anytime; transfer waits for time
// - counter captured as timestamp on transfer
// - enabled link takes the data pins from ports; serdes and strobe still run
// - enabled narrower port owns shared pins
// - unshared pins stay with the wider port
// - transfers always at full nominal width
// - six clock blocks; block 0 is reference
// - other blocks run at independent rates
// - block may take 1-bit port clock, divided
// - input strobe qualifies; output strobe accompanies
// - after reset port uses clock block 0
// - pin events go straight to scheduler
`default_nettype none
module iop_port #(
  parameter int WIDTH = 4,
  parameter int FIFO_DEPTH = iop_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // port configuration
  input wire logic port_en_i,
  input wire logic dir_out_i,
  input wire logic open_drain_i,
  input wire logic strobe_en_i,
  input wire iop_pkg::iop_cond_t cond_mode_i,
  input wire logic [WIDTH-1:0] cond_val_i,
  // pin sharing
  input wire logic link_en_i,
  input wire logic [WIDTH-1:0] taken_i,
  // clock blocks
  input wire logic clk_sel_wr_i,
  input wire logic [iop_pkg::CB_SEL_W-1:0] clk_sel_i,
  input wire logic [iop_pkg::CB_NUM-1:1] cb_ext_i,
  input wire logic [iop_pkg::CB_NUM-1:1][iop_pkg::DIV_W-1:0] cb_div_i,
  input wire logic ext_clk_i,
  // core output side
  input wire logic wr_valid_i,
  input wire logic [iop_pkg::XFER_W-1:0] wr_data_i,
  input wire logic wr_timed_i,
  input wire logic [iop_pkg::COUNT_W-1:0] time_i,
  output logic wr_ready_o,
  // core input side
  input wire logic in_arm_i,
  input wire logic rd_ready_i,
  output logic rd_valid_o,
  output logic [iop_pkg::XFER_W-1:0] rd_data_o,
  output logic [iop_pkg::COUNT_W-1:0] rd_stamp_o,
  // status
  output logic [iop_pkg::COUNT_W-1:0] count_o,
  output logic [iop_pkg::COUNT_W-1:0] timestamp_o,
  output logic event_o,
  // pins
  input wire logic [WIDTH-1:0] pin_i,
  input wire logic input_strobe_i,
  output logic [WIDTH-1:0] pin_o,
  output logic [WIDTH-1:0] pin_oe_o,
  output logic output_strobe_o
);
  localparam int XW = iop_pkg::XFER_W;
  localparam int CW = iop_pkg::COUNT_W;
  localparam int SW = iop_pkg::SLOT_W;
  localparam int DW = iop_pkg::DIV_W;
  localparam int NB = iop_pkg::CB_NUM;
  localparam int SLOTS = XW / WIDTH;
  localparam logic [SW-1:0] LAST_SLOT = SW'(SLOTS - 1);
  localparam int FW = XW + CW;

  // ==========================================================
  // clock blocks
  // block 0 ticks every reference edge; others divide the
  // reference or an edge of the 1-bit port clock
  logic ext_clk_q;
  logic [NB-1:0] cb_tick;
  logic [DW-1:0] cb_cnt [NB];
  wire ext_rise = ext_clk_i && !ext_clk_q;

  assign cb_tick[0] = 1'b1;
  assign cb_cnt[0] = iop_pkg::DIV_RESET;

  genvar gb;
  generate
    for (gb = 1; gb < NB; gb++) begin : g_cb
      wire raw = cb_ext_i[gb] ? ext_rise : 1'b1;
      wire hit = (cb_cnt[gb] == cb_div_i[gb]);
      assign cb_tick[gb] = raw && hit;
      always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          cb_cnt[gb] <= iop_pkg::DIV_RESET;
        end else if (raw) begin
          cb_cnt[gb] <= hit ? iop_pkg::DIV_RESET : cb_cnt[gb] + 1'b1;
        end
      end
    end
  endgenerate

  logic [iop_pkg::CB_SEL_W-1:0] clk_sel;
  // block numbers six and seven are dropped, the old choice stays
  wire sel_ok = (clk_sel_i < iop_pkg::CB_SEL_W'(NB));
  wire tick = cb_tick[clk_sel];

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ext_clk_q <= 1'b0;
      clk_sel <= iop_pkg::CB_RESET_SEL;
    end else begin
      ext_clk_q <= ext_clk_i;
      if (clk_sel_wr_i && sel_ok) begin
        clk_sel <= clk_sel_i;
      end
    end
  end

  // ==========================================================
  // port counter
  logic [CW-1:0] count;
  // free-running; wraps to zero with no flag

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count <= iop_pkg::COUNT_RESET;
    end else if (tick) begin
      count <= count + 1'b1;
    end
  end

  // ==========================================================
  // pin ownership
  // a taken pin still shifts a slot of data, it just goes nowhere
  wire port_live = port_en_i && !link_en_i;
  wire [WIDTH-1:0] own = {WIDTH{port_live}} & ~taken_i;
  wire [WIDTH-1:0] pins = pin_i & own;
  wire is_out = port_en_i && dir_out_i;
  wire is_in = port_en_i && !dir_out_i;

  // ==========================================================
  // output path: transfer register and serializer
  logic xfer_full;
  logic [XW-1:0] xfer_data;
  logic xfer_timed;
  logic [CW-1:0] xfer_time;
  logic [SW-1:0] out_slot;
  logic [WIDTH-1:0] pin_val;

  wire wr_take = wr_valid_i && !xfer_full;
  wire out_time_ok = !xfer_timed || (count == xfer_time);
  wire out_go = tick && is_out && xfer_full && out_time_ok;
  wire out_last = (out_slot == LAST_SLOT);

  // one block per register group keeps each update easy to follow
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      xfer_full <= 1'b0;
    end else if (wr_take) begin
      xfer_full <= 1'b1;
    end else if (out_go) begin
      xfer_full <= !out_last;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      xfer_data <= '0;
    end else if (wr_take) begin
      xfer_data <= wr_data_i;
    end else if (out_go) begin
      xfer_data <= xfer_data >> WIDTH;
    end
  end

  // the target time is used once, by the first slot only
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      xfer_timed <= 1'b0;
      xfer_time <= '0;
    end else if (wr_take) begin
      xfer_timed <= wr_timed_i;
      xfer_time <= time_i;
    end else if (out_go) begin
      xfer_timed <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      out_slot <= '0;
      pin_val <= '0;
    end else if (wr_take) begin
      out_slot <= '0;
    end else if (out_go) begin
      pin_val <= xfer_data[WIDTH-1:0];
      out_slot <= out_slot + 1'b1;
    end
  end

  // ==========================================================
  // input path: conditional, strobed, timed deserializer
  logic in_busy;
  logic in_hold;
  logic in_armed;
  logic [CW-1:0] in_time;
  logic [SW-1:0] in_slot;
  logic [XW-1:0] in_shift;
  logic [CW-1:0] in_stamp;

  wire cond_eq = (cond_mode_i == iop_pkg::IOP_COND_EQ) &&
                 (pins == cond_val_i);
  wire cond_neq = (cond_mode_i == iop_pkg::IOP_COND_NEQ) &&
                  (pins != cond_val_i);
  wire cond_ok = (cond_mode_i == iop_pkg::IOP_COND_NONE) || cond_eq ||
                 cond_neq;
  wire strobe_ok = !strobe_en_i || input_strobe_i;
  wire in_time_ok = !in_armed || (count == in_time);
  wire in_start = !in_busy && cond_ok && in_time_ok;
  wire in_go = tick && is_in && !in_hold && strobe_ok &&
               (in_busy || in_start);
  wire in_last = (in_slot == LAST_SLOT);
  wire [XW-1:0] pins_ext = XW'(pins);
  wire [XW-1:0] next_shift = (in_shift >> WIDTH) |
                             (pins_ext << (XW - WIDTH));

  // back-pressure: a held word blocks sampling until the fifo takes it
  iop_stream_if #(.W(FW)) push_if ();
  iop_stream_if #(.W(FW)) pop_if ();

  assign push_if.valid = in_hold;
  assign push_if.data = {in_stamp, in_shift};
  wire push_done = in_hold && push_if.ready;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      in_busy <= 1'b0;
      in_hold <= 1'b0;
      in_armed <= 1'b0;
      in_time <= '0;
      in_slot <= '0;
      in_shift <= '0;
      in_stamp <= '0;
    end else begin
      if (in_arm_i) begin
        in_armed <= 1'b1;
        in_time <= time_i;
      end else if (in_go && !in_busy) begin
        in_armed <= 1'b0;
      end
      if (push_done) begin
        in_hold <= 1'b0;
      end
      if (in_go) begin
        in_shift <= next_shift;
        if (!in_busy) begin
          in_stamp <= count;
        end
        in_busy <= !in_last;
        in_slot <= in_last ? '0 : in_slot + 1'b1;
        in_hold <= in_last;
      end
    end
  end

  iop_fifo #(
    .W(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .push(push_if),
    .pop(pop_if)
  );

  // ==========================================================
  // read stage: registered so core-facing outputs are flops
  wire rd_free = !rd_valid_o || rd_ready_i;
  assign pop_if.ready = rd_free;
  wire rd_load = rd_free && pop_if.valid;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_valid_o <= 1'b0;
      rd_data_o <= '0;
      rd_stamp_o <= '0;
    end else if (rd_free) begin
      rd_valid_o <= pop_if.valid;
      if (rd_load) begin
        rd_data_o <= pop_if.data[XW-1:0];
        rd_stamp_o <= pop_if.data[FW-1:XW];
      end
    end
  end

  // ==========================================================
  // pins and status
  wire [WIDTH-1:0] drv = own & {WIDTH{is_out}};
  // the slot value leaves with its strobe, not a cycle behind it
  wire [WIDTH-1:0] slot_val = out_go ? xfer_data[WIDTH-1:0] : pin_val;
  wire [WIDTH-1:0] next_pin = open_drain_i ? '0 : slot_val;
  wire [WIDTH-1:0] next_oe = open_drain_i ? (drv & ~slot_val) : drv;
  wire first_out = out_go && (out_slot == '0);
  wire word_done = (out_go && out_last) || (in_go && in_last);
  wire stamp_now = first_out || (in_go && !in_busy);

  // pins and strobe leave together from flops
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_o <= '0;
      pin_oe_o <= '0;
      output_strobe_o <= 1'b0;
    end else begin
      pin_o <= next_pin;
      pin_oe_o <= next_oe;
      output_strobe_o <= out_go && is_out;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ready_o <= 1'b0;
      count_o <= iop_pkg::COUNT_RESET;
      event_o <= 1'b0;
    end else begin
      wr_ready_o <= !xfer_full && !wr_take;
      count_o <= count;
      // no interrupt path: the pulse feeds the scheduler directly
      event_o <= word_done;
    end
  end

  // one stamp serves both directions; the latest start wins
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      timestamp_o <= '0;
    end else if (stamp_now) begin
      timestamp_o <= count;
    end
  end
endmodule
`default_nettype wire

// >>> hw/iop_pkg.sv
`default_nettype none
package iop_pkg;
  // ==========================================================
  // geometry
  localparam int XFER_W = 32;
  localparam int COUNT_W = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int SLOT_W = 6;
  localparam int CB_NUM = 6;
  localparam int CB_SEL_W = 3;
  localparam int DIV_W = 8;
  // ==========================================================
  // reset values and timing
  localparam logic [CB_SEL_W-1:0] CB_RESET_SEL = 3'h0;
  localparam int REF_CLK_MHZ = 100;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
  localparam logic [DIV_W-1:0] DIV_RESET = 8'h00;
  // ==========================================================
  // pin condition applied before an input transfer
  typedef enum logic [1:0] {
    IOP_COND_NONE,
    IOP_COND_EQ,
    IOP_COND_NEQ
  } iop_cond_t;
endpackage
`default_nettype wire

// >>> hw/iop_stream_if.sv
`default_nettype none
interface iop_stream_if #(
  parameter int W = 8
) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport tx (output valid, output data, input ready);
  modport rx (input valid, input data, output ready);
endinterface
`default_nettype wire

// >>> hw/iop_fifo.sv
`default_nettype none
module iop_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // streams
  iop_stream_if.rx push,
  iop_stream_if.tx pop
);
  localparam int AW = $clog2(DEPTH);
  // ==========================================================
  // storage and pointers, extra bit tells full from empty
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wptr;
  logic [AW:0] rptr;
  wire full = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
  wire empty = (wptr == rptr);
  wire do_push = push.valid && !full;
  wire do_pop = pop.ready && !empty;

  assign push.ready = !full;
  assign pop.valid = !empty;
  assign pop.data = mem[rptr[AW-1:0]];

  always_ff @(posedge sys_clk_i) begin
    if (do_push) begin
      mem[wptr[AW-1:0]] <= push.data;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      if (do_push) begin
        wptr <= wptr + 1'b1;
      end
      if (do_pop) begin
        rptr <= rptr + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb/iop_port_sva.sv
`default_nettype none
module iop_port_sva #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // configuration
  input wire logic port_en_i,
  input wire logic dir_out_i,
  input wire logic open_drain_i,
  input wire logic link_en_i,
  input wire logic [WIDTH-1:0] taken_i,
  // core side
  input wire logic wr_valid_i,
  input wire logic wr_ready_o,
  input wire logic rd_ready_i,
  input wire logic rd_valid_o,
  input wire logic [iop_pkg::XFER_W-1:0] rd_data_o,
  input wire logic [iop_pkg::COUNT_W-1:0] count_o,
  input wire logic event_o,
  // pins
  input wire logic [WIDTH-1:0] pin_o,
  input wire logic [WIDTH-1:0] pin_oe_o,
  input wire logic output_strobe_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  // ==========================================================
  // assertions
  property p_dir;
    !dir_out_i && $past(dir_out_i) == 1'b0 |-> pin_oe_o == '0;
  endproperty
  a_dir: assert property (p_dir) else $error("input port drives");
  property p_od;
    open_drain_i && output_strobe_o |-> pin_o == '0;
  endproperty
  a_od: assert property (p_od) else $error("open drain drives high");
  property p_take;
    port_en_i && dir_out_i && wr_valid_i && wr_ready_o |=> !wr_ready_o;
  endproperty
  a_take: assert property (p_take) else $error("word not taken");
  property p_done;
    $rose(wr_ready_o) && $past(nrst_i, 2) |-> $past(event_o);
  endproperty
  a_done: assert property (p_done) else $error("ready without event");
  property p_link;
    link_en_i && $past(link_en_i) |-> pin_oe_o == '0;
  endproperty
  a_link: assert property (p_link) else $error("pins driven under link");
  property p_taken;
    $stable(taken_i) |-> (pin_oe_o & taken_i) == '0;
  endproperty
  a_taken: assert property (p_taken) else $error("taken pin driven");
  property p_hold;
    rd_valid_o && !rd_ready_i |=> rd_valid_o && $stable(rd_data_o);
  endproperty
  a_hold: assert property (p_hold) else $error("read word dropped");
  property p_ostb;
    output_strobe_o && !open_drain_i && !link_en_i && $past(taken_i) == '0
      |-> pin_oe_o == '1;
  endproperty
  a_ostb: assert property (p_ostb) else $error("strobe without data");
  property p_count;
    $past(nrst_i) |-> 16'(count_o - $past(count_o)) <= 16'h0001;
  endproperty
  a_count: assert property (p_count) else $error("counter jumped");
  // ==========================================================
  // covers
  c_out: cover property (event_o && dir_out_i);
  c_in: cover property (rd_valid_o && rd_ready_i);
  c_od: cover property (output_strobe_o && open_drain_i);
endmodule
bind iop_port iop_port_sva #(.WIDTH(WIDTH)) u_sva (.*);
`default_nettype wire

// >>> tb/iop_pins_model.sv
`default_nettype none
module iop_pins_model #(
  parameter int W = 8
) (
  // clock
  input wire logic clk_i,
  // from port
  input wire logic [W-1:0] pad_i,
  input wire logic [W-1:0] oe_i,
  input wire logic ostb_i,
  // to port and bench
  output logic [W-1:0] pin_drv_o,
  output logic strobe_o = 1'b0,
  output logic got_o = 1'b0,
  output logic [31:0] word_o = '0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [W-1:0] drv = '0;
  logic [W-1:0] lvl;
  logic busy = 1'b0;
  int n = 0;
  // released pins float up to the pull-up
  assign lvl = (pad_i & oe_i) | ~oe_i;
  assign pin_drv_o = (oe_i & pad_i) | (~oe_i & drv);
  always @(posedge clk_i) begin
    got_o <= 1'b0;
    // idle lines toggle so a stale value never passes
    if (!busy) drv <= ~drv;
    if (ostb_i) begin
      word_o <= {lvl, word_o[31:W]};
      n <= (n + 1) % (32 / W);
      got_o <= n == 32 / W - 1;
    end
  end
  task automatic send(input logic [31:0] w);
    int k;
    int j;
    logic s;
    k = 0;
    j = 0;
    busy = 1'b1;
    // strobe gaps are random but bounded, so a word always ends
    while (k < 32 / W && j < 32) begin
      @(posedge clk_i);
      s = ($urandom_range(0, 3) != 0) || j >= 8;
      j++;
      strobe_o <= s;
      drv <= s ? w[k*W +: W] : ~drv;
      if (s) k++;
    end
    @(posedge clk_i);
    strobe_o <= 1'b0;
    busy = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int W = 8;
  logic sys_clk_i, nrst_i = 1'b0, dir_out = 1'b1, od = 1'b0;
  logic link_en = 1'b0, sel_wr = 1'b0, wr_valid = 1'b0, timed = 1'b0;
  logic rd_ready = 1'b1, hold = 1'b0, wr_ready, rd_valid, evt, ostb;
  logic istb, got;
  logic [W-1:0] taken = '0, pin_o, pin_oe, pin_i;
  logic [2:0] sel = '0;
  logic [5:1] cb_ext = 5'h01;
  logic ext_clk = 1'b0;
  logic [W-1:0] cval = '0;
  iop_pkg::iop_cond_t cond = iop_pkg::IOP_COND_NONE;
  logic [5:1][7:0] div = {8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
  logic [31:0] wdata = '0, rd_data, word, d;
  logic [15:0] tim = '0, rd_stamp, count, tstamp;
  logic [31:0] oq[$], iq[$];
  int num_errors = 0, checks_done = 0, n_evt = 0;
  iop_port #(.WIDTH(W)) u_dut (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .port_en_i(1'b1),
    .dir_out_i(dir_out), .open_drain_i(od), .strobe_en_i(1'b1),
    .cond_mode_i(cond), .cond_val_i(cval),
    .link_en_i(link_en), .taken_i(taken), .clk_sel_wr_i(sel_wr),
    .clk_sel_i(sel), .cb_ext_i(cb_ext), .cb_div_i(div),
    .ext_clk_i(ext_clk),
    .wr_valid_i(wr_valid), .wr_data_i(wdata), .wr_timed_i(timed),
    .time_i(tim), .wr_ready_o(wr_ready), .in_arm_i(1'b0),
    .rd_ready_i(rd_ready), .rd_valid_o(rd_valid), .rd_data_o(rd_data),
    .rd_stamp_o(rd_stamp), .count_o(count), .timestamp_o(tstamp),
    .event_o(evt), .pin_i(pin_i), .input_strobe_i(istb),
    .pin_o(pin_o), .pin_oe_o(pin_oe), .output_strobe_o(ostb)
  );
  iop_pins_model #(.W(W)) u_pins (
    .clk_i(sys_clk_i), .pad_i(pin_o), .oe_i(pin_oe), .ostb_i(ostb),
    .pin_drv_o(pin_i), .strobe_o(istb), .got_o(got), .word_o(word)
  );
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // ==========================================================
  // helpers
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic stop_test;
    if (num_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wait_for(input int n);
    int i;
    i = 0;
    while ((oq.size() + iq.size() != 0 || wr_ready !== 1'b1) && i < n) begin
      @(posedge sys_clk_i);
      i++;
    end
    if (i >= n) begin
      num_errors++;
      stop_test();
    end
  endtask
  task automatic put(input logic [31:0] v, e, input logic t);
    @(posedge sys_clk_i);
    wr_valid <= 1'b1;
    wdata <= v;
    timed <= t;
    tim <= count + 16'h0028;
    oq.push_back(e);
    @(posedge sys_clk_i);
    wr_valid <= 1'b0;
    timed <= 1'b0;
  endtask
  // window of 20 cycles; a slow block shows half the steps
  task automatic rate(input logic [2:0] s, input logic [15:0] e, logic w);
    logic [15:0] c0;
    @(posedge sys_clk_i);
    sel <= s;
    sel_wr <= w;
    @(posedge sys_clk_i);
    sel_wr <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    c0 = count;
    repeat (20) @(posedge sys_clk_i);
    chk("count rate", {16'h0000, e}, {16'h0000, 16'(count - c0)});
  endtask
  // ==========================================================
  // result watcher
  always @(posedge sys_clk_i) begin
    if (got === 1'b1) chk("pin word", oq.pop_front(), word);
    if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
      chk("rd", iq.pop_front(), rd_data);
    end
    if (evt === 1'b1) n_evt++;
    ext_clk <= ~ext_clk;
    rd_ready <= hold ? 1'b0 : 1'($urandom);
  end
  // ==========================================================
  // scenarios
  initial begin
    void'($urandom(21));
    repeat (2) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    rate(3'h0, 16'h0014, 1'b0);
    rate(3'h2, 16'h000A, 1'b1);
    rate(3'h7, 16'h000A, 1'b1);
    rate(3'h1, 16'h000A, 1'b1);
    rate(3'h0, 16'h0014, 1'b1);
    for (int k = 0; k < 4; k++) begin
      d = $urandom;
      od <= k[0];
      taken <= k == 2 ? 8'h0F : 8'h00;
      put(d, k == 2 ? d | {4{8'h0F}} : d, k == 3);
      wait_for(300);
    end
    chk("timestamp", {16'h0000, tim}, {16'h0000, tstamp});
    link_en <= 1'b1;
    repeat (5) @(posedge sys_clk_i);
    link_en <= 1'b0;
    dir_out <= 1'b0;
    hold <= 1'b1;
    for (int k = 0; k < 16; k++) begin
      d = $urandom;
      cond <= k[0] ? iop_pkg::IOP_COND_NONE : iop_pkg::IOP_COND_EQ;
      cval <= d[W-1:0];
      iq.push_back(d);
      u_pins.send(d);
    end
    hold <= 1'b0;
    wait_for(600);
    chk("events", 32'h00000014, n_evt);
    stop_test();
  end
endmodule
`default_nettype wire
